// ==== src/adc_cal_pkg.sv ====
// Shared constants and types for the converter calibration and reset sequencer
package adc_cal_pkg;

    // ==================================================================
    // Clock and timing
    // ==================================================================
    localparam int CLK_MHZ         = 250;
    localparam int CAL_NOM_MS      = 200;
    localparam int CAL_MAX_MS      = 550;
    localparam int CAL_NOM_CYCLES  = CAL_NOM_MS * 1000 * CLK_MHZ;
    localparam int CAL_MAX_CYCLES  = CAL_MAX_MS * 1000 * CLK_MHZ;
    localparam int DLL_LOCK_US     = 52;
    localparam int DLL_LOCK_CYCLES = DLL_LOCK_US * CLK_MHZ;
    localparam int CAL_CNT_W       = 28;
    localparam int LOCK_CNT_W      = 16;

    // ==================================================================
    // Conversion pipeline
    // ==================================================================
    localparam int DATA_W          = 12;
    // Seven and a half sample periods, counted in half-period ticks
    localparam int LATENCY_TICKS   = 15;
    localparam logic [DATA_W-1:0] FULL_SCALE = 12'hFFF;

    // ==================================================================
    // Tri-level divider select encodings (pad comparator outputs)
    // ==================================================================
    localparam logic [1:0] PIN_TIED_LOW  = 2'h0;
    localparam logic [1:0] PIN_FLOATING  = 2'h1;
    localparam logic [1:0] PIN_TIED_HIGH = 2'h2;

    typedef enum logic [1:0] {
        DIV_BY_1 = 2'h0,
        DIV_BY_2 = 2'h1,
        DIV_BY_4 = 2'h2
    } div_ratio_t;

    typedef enum logic [2:0] {
        ST_HELD = 3'h1,
        ST_CAL  = 3'h2,
        ST_RUN  = 3'h4
    } cal_state_t;

    // ==================================================================
    // Carriers
    // ==================================================================
    typedef struct packed {
        logic       valid;
        div_ratio_t ratio;
    } cfg_div_t;

    typedef struct packed {
        logic              valid;
        logic              over_range;
        logic [DATA_W-1:0] code;
    } adc_out_t;

    typedef struct packed {
        logic p;
        logic n;
    } clock_pair_t;

endpackage : adc_cal_pkg

// ==== src/adc_cal_sequencer.sv ====
// Calibration, reset and clock-divide sequencer of a pipelined sampling converter
//
// Operation
// - Results appear seven and a half sample periods after conversion start.
// - Calibration starts on the rising edge of the recalibration input.
// - Supply monitor holds the input low, then releases; pull-up starts calibration.
// - Over-range forced high from recalibration low until calibration completes.
// - Over-range input at calibration end simply keeps the flag high.
// - Output clock pair held low while the recalibration input is low.
// - Output clock resumes on the first tick after the release has passed the two-flop synchroniser.
// - Calibration lasts nominally 200 ms, at most 550 ms, at full rate.
// - Divider pin: low gives ratio 2, floating 1, high 4.
// - A serially written divide ratio overrides the divider pin.
// - Delay-locked loop relocks within 52 us at full rate after a change.
`timescale 1ns/10ps
`default_nettype none

module adc_cal_sequencer #(
    parameter int CAL_CYCLES     = adc_cal_pkg::CAL_NOM_CYCLES,
    parameter int DLL_LOCK_TICKS = adc_cal_pkg::DLL_LOCK_CYCLES
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    // Supply monitor
    input  wire logic                          supply_good,
    // Recalibration pin, open drain
    input  wire logic                          recal_trigger_n_in,
    output logic                               recal_trigger_n_out,
    output logic                               recal_trigger_oe_n,
    // Divider select pin and serial override
    input  wire logic [1:0]                    divider_select_pin,
    input  wire adc_cal_pkg::cfg_div_t         cfg_div,
    // Host activity watched during calibration
    input  wire logic                          spi_select_n,
    input  wire logic                          sdo_level,
    // Converter core result
    input  wire logic [adc_cal_pkg::DATA_W-1:0] sample_code,
    // Outputs
    output adc_cal_pkg::adc_out_t              conv_out,
    output adc_cal_pkg::clock_pair_t           output_clock_pair,
    output logic                               cal_busy,
    output logic                               cal_fault,
    output logic                               dll_locked,
    output adc_cal_pkg::div_ratio_t            div_ratio_active
);

    localparam logic [adc_cal_pkg::CAL_CNT_W-1:0] CAL_LAST =
        adc_cal_pkg::CAL_CNT_W'(CAL_CYCLES - 1);
    localparam logic [adc_cal_pkg::LOCK_CNT_W-1:0] LOCK_LOAD =
        adc_cal_pkg::LOCK_CNT_W'(DLL_LOCK_TICKS);

    // ==================================================================
    // Pin synchronisers
    // ==================================================================
    logic [1:0] div_pin_s;
    logic       supply_good_s;
    logic       recal_pin_s;
    logic       spi_select_n_s;
    logic       sdo_level_s;

    pin_sync #(.WIDTH(2), .RESET_VAL(32'h1)) u_div_sync (
        .clk          (clk),
        .reset_n      (reset_n),
        .pin_in       (divider_select_pin),
        .pin_sync_out (div_pin_s)
    );

    // Reset values leave the trigger low and host lines idle
    pin_sync #(.WIDTH(4), .RESET_VAL(32'hC)) u_ctl_sync (
        .clk          (clk),
        .reset_n      (reset_n),
        .pin_in       ({spi_select_n, sdo_level, recal_trigger_n_in, supply_good}),
        .pin_sync_out ({spi_select_n_s, sdo_level_s, recal_pin_s, supply_good_s})
    );

    // ==================================================================
    // Power-on hold of the recalibration pin
    // ==================================================================
    logic trigger_level;
    logic trigger_prev;
    logic trigger_rise;

    // Pin is pulled low until supplies are good, then left to the pull-up
    assign recal_trigger_n_out = 1'b0;
    assign recal_trigger_oe_n  = supply_good_s;

    // Own drive is also folded in so the hold cannot be missed
    assign trigger_level = recal_pin_s & supply_good_s;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trigger_prev <= 1'b0;
        end else begin
            trigger_prev <= trigger_level;
        end
    end

    assign trigger_rise = trigger_level & ~trigger_prev;

    // ==================================================================
    // Divide ratio selection
    // ==================================================================
    adc_cal_pkg::div_ratio_t pin_ratio;
    adc_cal_pkg::div_ratio_t cfg_ratio;
    adc_cal_pkg::div_ratio_t next_ratio;
    logic                    cfg_override;

    always_comb begin
        case (div_pin_s)
            adc_cal_pkg::PIN_TIED_LOW:  pin_ratio = adc_cal_pkg::DIV_BY_2;
            adc_cal_pkg::PIN_TIED_HIGH: pin_ratio = adc_cal_pkg::DIV_BY_4;
            default:                    pin_ratio = adc_cal_pkg::DIV_BY_1;
        endcase
    end

    // A serial write latches and then outranks the pin for good
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_override <= 1'b0;
            cfg_ratio    <= adc_cal_pkg::DIV_BY_1;
        end else if (cfg_div.valid) begin
            cfg_override <= 1'b1;
            cfg_ratio    <= cfg_div.ratio;
        end
    end

    assign next_ratio = cfg_override ? cfg_ratio : pin_ratio;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ratio_active <= adc_cal_pkg::DIV_BY_1;
        end else begin
            div_ratio_active <= next_ratio;
        end
    end

    logic tick;

    clock_divider u_divider (
        .clk     (clk),
        .reset_n (reset_n),
        .ratio   (div_ratio_active),
        .tick    (tick)
    );

    // ==================================================================
    // Delay-locked loop relock model
    // ==================================================================
    logic [adc_cal_pkg::LOCK_CNT_W-1:0] lock_count;

    // Counting ticks, not clocks, makes lock time scale with the rate
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_count <= LOCK_LOAD;
        end else if (next_ratio != div_ratio_active) begin
            lock_count <= LOCK_LOAD;
        end else if (tick && lock_count != '0) begin
            lock_count <= lock_count - 1'b1;
        end
    end

    assign dll_locked = (lock_count == '0);

    // ==================================================================
    // Calibration state machine
    // ==================================================================
    adc_cal_pkg::cal_state_t        state;
    logic [adc_cal_pkg::CAL_CNT_W-1:0] cal_count;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= adc_cal_pkg::ST_HELD;
        end else if (!trigger_level) begin
            // Any low pulse of one sample clock or more restarts
            state <= adc_cal_pkg::ST_HELD;
        end else begin
            case (state)
                adc_cal_pkg::ST_HELD: begin
                    if (trigger_rise) begin
                        state <= adc_cal_pkg::ST_CAL;
                    end
                end
                adc_cal_pkg::ST_CAL: begin
                    if (cal_count == CAL_LAST) begin
                        state <= adc_cal_pkg::ST_RUN;
                    end
                end
                adc_cal_pkg::ST_RUN: begin
                    state <= adc_cal_pkg::ST_RUN;
                end
                default: begin
                    state <= adc_cal_pkg::ST_HELD;
                end
            endcase
        end
    end

    // Duration assumes the sample clock stays running and stable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_count <= '0;
        end else if (state != adc_cal_pkg::ST_CAL) begin
            cal_count <= '0;
        end else begin
            cal_count <= cal_count + 1'b1;
        end
    end

    assign cal_busy = (state != adc_cal_pkg::ST_RUN);

    // ==================================================================
    // Host misuse during calibration
    // ==================================================================
    // Sticky until the next recalibration request; set and clear never overlap
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_fault <= 1'b0;
        end else if (state == adc_cal_pkg::ST_CAL &&
                     (!spi_select_n_s || !sdo_level_s)) begin
            cal_fault <= 1'b1;
        end else if (state == adc_cal_pkg::ST_HELD) begin
            cal_fault <= 1'b0;
        end
    end

    // ==================================================================
    // Conversion pipeline
    // ==================================================================
    // Ticks come at twice the conversion rate: a conversion starts on every
    // other tick, so fifteen ticks of delay give seven and a half periods.
    logic                         conv_phase;
    logic [adc_cal_pkg::DATA_W-1:0] pipe_code [0:adc_cal_pkg::LATENCY_TICKS];
    logic                         pipe_vld  [0:adc_cal_pkg::LATENCY_TICKS];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_phase <= 1'b0;
        end else if (tick) begin
            conv_phase <= ~conv_phase;
        end
    end

    assign pipe_code[0] = sample_code;
    assign pipe_vld[0]  = ~conv_phase & dll_locked;

    genvar s;
    generate
        for (s = 1; s <= adc_cal_pkg::LATENCY_TICKS; s++) begin : g_stage
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pipe_code[s] <= '0;
                    pipe_vld[s]  <= 1'b0;
                end else if (tick) begin
                    pipe_code[s] <= pipe_code[s-1];
                    pipe_vld[s]  <= pipe_vld[s-1];
                end
            end
        end
    endgenerate

    // ==================================================================
    // Output data and over-range flag
    // ==================================================================
    logic [adc_cal_pkg::DATA_W-1:0] last_code;
    logic                         last_vld;

    assign last_code = pipe_code[adc_cal_pkg::LATENCY_TICKS];
    assign last_vld  = pipe_vld[adc_cal_pkg::LATENCY_TICKS];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_out.code  <= '0;
            conv_out.valid <= 1'b0;
        end else begin
            conv_out.valid <= tick & last_vld & ~cal_busy;
            if (tick && last_vld) begin
                conv_out.code <= last_code;
            end
        end
    end

    // Full scale after calibration keeps the flag up with no visible edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_out.over_range <= 1'b1;
        end else if (!trigger_level || cal_busy) begin
            conv_out.over_range <= 1'b1;
        end else if (tick && last_vld) begin
            conv_out.over_range <= (last_code == adc_cal_pkg::FULL_SCALE);
        end
    end

    // ==================================================================
    // Output clock pair
    // ==================================================================
    logic oclk;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oclk <= 1'b0;
        end else if (!trigger_level) begin
            oclk <= 1'b0;
        end else if (tick) begin
            oclk <= ~oclk;
        end
    end

    assign output_clock_pair.p = oclk;
    assign output_clock_pair.n = ~oclk;

endmodule : adc_cal_sequencer

`default_nettype wire

// ==== src/clock_divider.sv ====
// Input clock divider producing one-cycle tick enables
`timescale 1ns/10ps
`default_nettype none

module clock_divider (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Ratio and tick
    input  wire adc_cal_pkg::div_ratio_t ratio,
    output logic                        tick
);

    logic [1:0] count;
    logic [1:0] limit;

    always_comb begin
        case (ratio)
            adc_cal_pkg::DIV_BY_2: limit = 2'h1;
            adc_cal_pkg::DIV_BY_4: limit = 2'h3;
            default:               limit = 2'h0;
        endcase
    end

    // ==================================================================
    // Counter; a ratio change restarts cleanly at the next wrap
    // ==================================================================
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 2'h0;
        end else if (count >= limit) begin
            count <= 2'h0;
        end else begin
            count <= count + 2'h1;
        end
    end

    assign tick = (count >= limit);

endmodule : clock_divider

`default_nettype wire

// ==== src/pin_sync.sv ====
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [31:0] RESET_VAL = 32'h0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Pins and synchronised levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync_out
);

    logic [WIDTH-1:0] stage1;

    // ==================================================================
    // One synchroniser per bit
    // ==================================================================
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    stage1[i]       <= RESET_VAL[i];
                    pin_sync_out[i] <= RESET_VAL[i];
                end else begin
                    stage1[i]       <= pin_in[i];
                    pin_sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

// ==== verification/adc_cal_chk.sv ====
// Port assertions for the calibration sequencer
`timescale 1ns/10ps
`default_nettype none

module adc_cal_chk #(
    parameter int CAL_CYCLES     = 20
) (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     reset_n,
    // Inputs of the sequencer
    input wire logic                     supply_good,
    input wire logic                     recal_trigger_n_in,
    input wire logic [1:0]               divider_select_pin,
    input wire adc_cal_pkg::cfg_div_t    cfg_div,
    input wire logic [11:0]              sample_code,
    // Outputs of the sequencer
    input wire adc_cal_pkg::adc_out_t    conv_out,
    input wire adc_cal_pkg::clock_pair_t output_clock_pair,
    input wire logic                     cal_busy,
    input wire adc_cal_pkg::div_ratio_t  div_ratio_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ==========================================================
    // Helper state
    // ==========================================================
    int                      cal_cnt;
    logic                    cfg_seen;
    adc_cal_pkg::div_ratio_t pin_ratio;

    // A low pin restarts the busy count, as a recalibration does
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_cnt  <= 0;
            cfg_seen <= 1'b0;
        end else begin
            cal_cnt  <= (recal_trigger_n_in && supply_good && cal_busy) ? cal_cnt + 1 : 0;
            cfg_seen <= cfg_seen || cfg_div.valid;
        end
    end

    always_comb begin
        case (divider_select_pin)
            adc_cal_pkg::PIN_TIED_LOW:  pin_ratio = adc_cal_pkg::DIV_BY_2;
            adc_cal_pkg::PIN_TIED_HIGH: pin_ratio = adc_cal_pkg::DIV_BY_4;
            default:                    pin_ratio = adc_cal_pkg::DIV_BY_1;
        endcase
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    clk_held_a: assert property ((!recal_trigger_n_in)[*5] |->
        !output_clock_pair.p && output_clock_pair.n)
        else $error("output clock not low while recalibration held");
    clk_runs_a: assert property ((recal_trigger_n_in && supply_good &&
        div_ratio_active == adc_cal_pkg::DIV_BY_1)[*5] |-> output_clock_pair.p != $past(output_clock_pair.p))
        else $error("output clock not toggling after release");
    busy_held_a: assert property ((!recal_trigger_n_in)[*5] |-> cal_busy)
        else $error("busy low while recalibration held");
    or_forced_a: assert property (cal_busy[*8] |-> conv_out.over_range)
        else $error("over-range low during calibration");
    cal_time_a: assert property ($fell(cal_busy) |->
        cal_cnt >= CAL_CYCLES && cal_cnt <= CAL_CYCLES + 8)
        else $error("calibration length out of bounds");
    pipe_delay_a: assert property (conv_out.valid && div_ratio_active == adc_cal_pkg::DIV_BY_1 &&
        $past(div_ratio_active, 20) == adc_cal_pkg::DIV_BY_1 |-> conv_out.code == $past(sample_code, 16))
        else $error("result latency wrong");
    cfg_ratio_a: assert property (cfg_div.valid |-> ##2
        div_ratio_active == $past(cfg_div.ratio, 2))
        else $error("written ratio not applied");
    pin_ratio_a: assert property ((!cfg_seen && $stable(divider_select_pin))[*5] |->
        div_ratio_active == pin_ratio)
        else $error("pin ratio mapping wrong");

    cal_done_c:  cover property ($fell(cal_busy));
    or_out_c:    cover property (conv_out.valid && conv_out.over_range);
    cfg_write_c: cover property (cfg_div.valid);
endmodule : adc_cal_chk

bind adc_cal_sequencer adc_cal_chk #(.CAL_CYCLES(CAL_CYCLES)) chk_u (.*);

`default_nettype wire

// ==== verification/host_ctrl_model.sv ====
// Behavioural host controller facing the calibration sequencer
`timescale 1ns/10ps
`default_nettype none

module host_ctrl_model (
    // Clock
    input  wire logic clk,
    // Orders from the bench
    input  wire logic req_recal,
    input  wire logic bad_sdo,
    input  wire logic bad_sel,
    // Device side of the open-drain recalibration pin
    input  wire logic dev_out,
    input  wire logic dev_oe_n,
    // Lines seen by the device
    output logic      recal_pin,
    output logic      sdo_level,
    output logic      spi_select_n
);
    logic pull = 1'b0;

    // ==========================================================
    // Recalibration request
    // ==========================================================
    // Whole clock cycles only, so a request is never shorter than one
    always @(posedge clk) begin
        pull <= req_recal;
    end

    // Open drain: any puller wins, the pull-up gives high otherwise
    assign recal_pin = !((!dev_oe_n && !dev_out) || pull);

    // ==========================================================
    // Serial port left idle unless misuse is ordered
    // ==========================================================
    assign sdo_level    = !bad_sdo;
    assign spi_select_n = !bad_sel;
endmodule : host_ctrl_model

`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the calibration sequencer
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    localparam int CAL = 20;
    localparam int DLL = 8;

    logic                     clk = 1'b0;
    logic                     reset_n = 1'b0;
    logic                     supply_good = 1'b0;
    logic                     req = 1'b0, bad_sdo = 1'b0, bad_sel = 1'b0, full_in = 1'b0;
    logic [1:0]               div_pin = adc_cal_pkg::PIN_FLOATING;
    logic [11:0]              code_in = 12'h000;
    adc_cal_pkg::cfg_div_t    cfg = '0;
    logic                     pin, oe_n, od_out, sdo, sel_n, busy, fault, locked;
    adc_cal_pkg::adc_out_t    q;
    adc_cal_pkg::clock_pair_t ck;
    adc_cal_pkg::div_ratio_t  ratio;
    int                       cyc = 0, failures = 0, cmp_count = 0;

    // ==========================================================
    // Clock, ramp stimulus and hang guard
    // ==========================================================
    initial forever #2 clk = ~clk;

    // Ramp: each result names its sample cycle
    always @(negedge clk) code_in <= full_in ? adc_cal_pkg::FULL_SCALE : cyc[11:0];

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            wrap_up();
        end
    end

    host_ctrl_model host_u (.clk(clk), .req_recal(req), .bad_sdo(bad_sdo), .bad_sel(bad_sel),
        .dev_out(od_out), .dev_oe_n(oe_n), .recal_pin(pin), .sdo_level(sdo), .spi_select_n(sel_n));

    adc_cal_sequencer #(.CAL_CYCLES(CAL), .DLL_LOCK_TICKS(DLL)) dut_u (
        .clk(clk), .reset_n(reset_n), .supply_good(supply_good), .recal_trigger_n_in(pin),
        .recal_trigger_n_out(od_out), .recal_trigger_oe_n(oe_n), .divider_select_pin(div_pin),
        .cfg_div(cfg), .spi_select_n(sel_n), .sdo_level(sdo), .sample_code(code_in),
        .conv_out(q), .output_clock_pair(ck), .cal_busy(busy), .cal_fault(fault),
        .dll_locked(locked), .div_ratio_active(ratio));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(input string what, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    // 0: idle, 1: result, 2: locked; bounded wait
    task automatic wait_for(input int which, output int n);
        n = 0;
        while (n < 200 && !(which == 0 ? busy === 1'b0 :
                            which == 1 ? q.valid === 1'b1 : locked === 1'b1)) begin
            step(1);
            n++;
        end
    endtask : wait_for

    task automatic wrap_up();
        $display("TB: %0d comparisons, %0d failures", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_powerup();
        int n;
        chk_bit("busy_held", 1'b1, busy);
        chk_bit("pin_held", 1'b0, pin);
        chk_bit("clk_held", 1'b0, ck.p);
        supply_good = 1'b1;
        step(4);
        chk_bit("pin_released", 1'b1, pin);
        chk_bit("or_forced", 1'b1, q.over_range);
        wait_for(0, n);
        chk_bit("cal_time", 1'b1, n + 4 >= CAL && n <= CAL + 10);
        $display("TB: power-up test done");
    endtask : t_powerup

    task automatic t_latency();
        int n;
        repeat (3) begin
            wait_for(1, n);
            chk_word("code", 12'(cyc - 16), q.code);
            chk_bit("or_flag", q.code === adc_cal_pkg::FULL_SCALE, q.over_range);
            step(1);
        end
        $display("TB: latency test done");
    endtask : t_latency

    task automatic t_recal();
        int   n;
        logic p0;
        req = 1'b1;
        step(1);
        req = 1'b0;
        step(5);
        chk_bit("busy_on_pulse", 1'b1, busy);
        bad_sdo = 1'b1;
        step(4);
        chk_bit("fault_sdo", 1'b1, fault);
        bad_sdo = 1'b0;
        req = 1'b1;
        step(7);
        chk_bit("clk_low", 1'b0, ck.p);
        chk_bit("fault_clear", 1'b0, fault);
        req = 1'b0;
        step(5);
        p0 = ck.p;
        step(1);
        chk_bit("clk_runs", ~p0, ck.p);
        bad_sel = 1'b1;
        step(4);
        chk_bit("fault_sel", 1'b1, fault);
        bad_sel = 1'b0;
        wait_for(0, n);
        chk_bit("recal_time", 1'b1, n + 10 >= CAL && n <= CAL);
        $display("TB: recalibration test done");
    endtask : t_recal

    task automatic t_range();
        int n;
        full_in = 1'b1;
        req = 1'b1;
        step(2);
        req = 1'b0;
        step(5);
        wait_for(0, n);
        repeat (8) begin
            step(1);
            chk_bit("or_kept", 1'b1, q.over_range);
        end
        wait_for(1, n);
        chk_word("code_full", adc_cal_pkg::FULL_SCALE, q.code);
        full_in = 1'b0;
        $display("TB: over-range test done");
    endtask : t_range

    task automatic t_divider();
        logic [1:0] pins [3] = '{adc_cal_pkg::PIN_TIED_LOW, adc_cal_pkg::PIN_FLOATING,
                                 adc_cal_pkg::PIN_TIED_HIGH};
        adc_cal_pkg::div_ratio_t want [3] = '{adc_cal_pkg::DIV_BY_2, adc_cal_pkg::DIV_BY_1,
                                              adc_cal_pkg::DIV_BY_4};
        int n;
        foreach (pins[i]) begin
            div_pin = pins[i];
            step(5);
            chk_word("pin_ratio", 12'(want[i]), 12'(ratio));
            chk_bit("dll_unlocked", 1'b0, locked);
            wait_for(2, n);
            chk_bit("dll_time", 1'b1, n <= 4 * DLL + 8);
        end
        cfg = '{valid: 1'b1, ratio: adc_cal_pkg::DIV_BY_2};
        step(1);
        cfg = '0;
        div_pin = adc_cal_pkg::PIN_FLOATING;
        step(6);
        chk_word("cfg_ratio", 12'(adc_cal_pkg::DIV_BY_2), 12'(ratio));
        $display("TB: divider test done");
    endtask : t_divider

    initial begin
        step(8);
        reset_n = 1'b1;
        t_powerup();
        t_latency();
        t_recal();
        t_range();
        t_divider();
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
